// ===== design/bit_i2c_pkg.sv
package bit_i2c_pkg;

	// register byte addresses on the apb side
	localparam logic [7:0] CFG_ADDR = 8'hC8;
	localparam logic [7:0] CTRL_ADDR = 8'hD0;
	localparam logic [7:0] DATA_ADDR = 8'hD4;

	// control register, write side
	localparam int CTL_CLR_XMIT = 7;
	localparam int CTL_IDLE = 6;
	localparam int CTL_CLR_RDY = 5;
	localparam int CTL_CLR_ARB = 4;
	localparam int CTL_CLR_START = 3;
	localparam int CTL_CLR_STOP = 2;
	localparam int CTL_SEND_RSTART = 1;
	localparam int CTL_SEND_STOP = 0;
	// control register, read side
	localparam int CTL_RX = 7;
	localparam int CTL_ATTN = 6;
	localparam int CTL_RDY = 5;
	localparam int CTL_ARB = 4;
	localparam int CTL_START = 3;
	localparam int CTL_STOP = 2;
	localparam int CTL_MST = 1;

	// data register and configuration register fields
	localparam int DAT_BIT = 7;
	localparam int CFG_SLAVE_EN = 7;
	localparam int CFG_MST_REQ = 6;
	localparam int CFG_CLR_TOV = 5;
	localparam int CFG_TMR_RUN = 4;
	localparam int CFG_RATE_LO = 0;
	localparam int CFG_RATE_HI = 1;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// timing
	localparam int CLK_MHZ = 100;
	localparam int MIN_SCL_NS = 5000;
	localparam int MIN_SCL_CYC = (MIN_SCL_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMEOUT_US = 250;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int HALF_W = 10;
	localparam int TO_W = 20;

endpackage : bit_i2c_pkg

// ===== design/bit_level_i2c_port.sv
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - arbitration loss only while transmitting; a set loss flag clears transmit-active.
// - sent one or repeated start but SDA low at SCL rise means loss.
// - sent one while another party makes a start: loss plus start flag.
// - master repeated start beaten by SCL falling first means loss.
// - master stop that cannot complete because SDA stays low means loss.
// - start flag set at master or active slave, not when idle slave wakes.
// - stop flag set at master or active slave only.
// - become master when requested and bus free since reset, timeout or stop.
// - leave master on loss, or on stop after request dropped before send-stop.
// - data write, repeated-start or stop request sets transmit-active.
// - SDA pulled low, except for own start, and loss flagged only while transmit-active.
// - data read or clear-transmit-active bit clears transmit-active.
// - idle bit ignores bus until next start; stop then makes requesting master.
// - clear-data-ready bit, data read or data write clears bit-ready.
// - each clear bit clears its own flag independently.
// - any flag set holds SCL low until software clears all.
// - repeated start requested with clear-data-ready, masters only; initial start automatic.
// - repeated start sends a one, then pulls SDA low after SCL high time.
// - stop sends a zero, then releases SDA after SCL high time.
// - slave enable bit; clears on reset and bus timeout.
// - attention reads one whenever any of the four flags is set.
// - SDA captured into received bit at each SCL rise; bit-ready set there only while active.
// - new transmit bit reaches SDA only while SCL is low.
// - request raised mid-transfer waits for a stop.
module bit_level_i2c_port
	import bit_i2c_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);

	logic scl_s1_q, scl_s2_q, scl_p_q;
	logic sda_s1_q, sda_s2_q, sda_p_q;
	logic [HALF_W-1:0] half_q;
	logic [TO_W-1:0] to_q;
	logic slave_en_q, mst_req_q, tmr_run_q;
	logic [1:0] rate_q;
	logic bit_ready_q, arb_lost_q, start_seen_q, stop_seen_q;
	logic xmit_q, master_q, idle_q, busy_q, tx_bit_q, rx_bit_q;
	logic rs_pend_q, stop_pend_q, stop_rel_q, rel_pend_q, gen_start_q;
	logic sda_pull_q, scl_pull_q;
	logic acc, wr, rd, wr_ctrl, wr_data, wr_cfg, rd_data, mapped;
	logic scl_rise, scl_fall, sda_edge, start_det, stop_det;
	logic half_done, timeout, enabled, active, attention, arb_evt;
	logic [7:0] ctrl_rd, cfg_rd, rd_val;

	// apb decode; a transfer completes on the edge where pready is seen high
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign wr_ctrl = wr & (paddr == CTRL_ADDR);
	assign wr_data = wr & (paddr == DATA_ADDR);
	assign wr_cfg = wr & (paddr == CFG_ADDR);
	assign rd_data = rd & (paddr == DATA_ADDR);
	assign mapped = (paddr == CTRL_ADDR) | (paddr == DATA_ADDR) | (paddr == CFG_ADDR);

	// synchronised bus events; only the second stage and later are read
	assign scl_rise = scl_s2_q & ~scl_p_q;
	assign scl_fall = ~scl_s2_q & scl_p_q;
	assign sda_edge = sda_s2_q ^ sda_p_q;
	assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
	assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
	assign half_done = (half_q == HALF_W'(MIN_SCL_CYC));
	assign timeout = (to_q == TO_W'(TIMEOUT_CYCLES));

	// the port is disabled only with enable, request and mastership all low
	assign enabled = slave_en_q | mst_req_q | master_q;
	assign active = enabled & (~idle_q | master_q);
	assign attention = bit_ready_q | arb_lost_q | start_seen_q | stop_seen_q;

	// the four loss cases, all gated by transmit-active
	assign arb_evt = xmit_q & active & (
		(scl_rise & ~sda_s2_q & ~sda_pull_q) |
		(start_det & ~sda_pull_q & ~gen_start_q) |
		(master_q & rs_pend_q & scl_fall & ~sda_pull_q) |
		(master_q & stop_rel_q & scl_fall));

	// two-flop synchronisers plus a history stage for edge finding
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_p_q <= scl_s2_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_p_q <= sda_s2_q;
		end
	end

	// time since the last line edge, saturating at the minimum half period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			half_q <= '0;
		end else if (scl_rise | scl_fall | sda_edge) begin
			half_q <= '0;
		end else if (!half_done) begin
			half_q <= half_q + 1'b1;
		end
	end

	// bus timeout: scl frozen too long during a message while the timer runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			to_q <= '0;
		end else if (!tmr_run_q || !busy_q || scl_rise || scl_fall || timeout) begin
			to_q <= '0;
		end else begin
			to_q <= to_q + 1'b1;
		end
	end

	// configuration register; a timeout drops both enables
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			slave_en_q <= CFG_RESET[CFG_SLAVE_EN];
			mst_req_q <= CFG_RESET[CFG_MST_REQ];
			tmr_run_q <= CFG_RESET[CFG_TMR_RUN];
			rate_q <= CFG_RESET[CFG_RATE_HI:CFG_RATE_LO];
		end else if (timeout) begin
			slave_en_q <= 1'b0;
			mst_req_q <= 1'b0;
		end else if (wr_cfg) begin
			slave_en_q <= pwdata[CFG_SLAVE_EN];
			mst_req_q <= pwdata[CFG_MST_REQ];
			tmr_run_q <= pwdata[CFG_TMR_RUN];
			rate_q <= pwdata[CFG_RATE_HI:CFG_RATE_LO];
		end
	end

	// bit-ready: set by scl rise or own start, set beats clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_ready_q <= 1'b0;
		end else if ((scl_rise & active) | (gen_start_q & start_det)) begin
			bit_ready_q <= 1'b1;
		end else if ((wr_ctrl & pwdata[CTL_CLR_RDY]) | rd_data | wr_data) begin
			bit_ready_q <= 1'b0;
		end
	end

	// received bit follows sda at every scl rise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_bit_q <= 1'b0;
		end else if (scl_rise) begin
			rx_bit_q <= sda_s2_q;
		end
	end

	// arbitration-lost flag
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			arb_lost_q <= 1'b0;
		end else if (arb_evt) begin
			arb_lost_q <= 1'b1;
		end else if (wr_ctrl & pwdata[CTL_CLR_ARB]) begin
			arb_lost_q <= 1'b0;
		end
	end

	// start flag; an idle slave woken by the start does not flag it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			start_seen_q <= 1'b0;
		end else if (start_det & active & ~gen_start_q) begin
			start_seen_q <= 1'b1;
		end else if (wr_ctrl & pwdata[CTL_CLR_START]) begin
			start_seen_q <= 1'b0;
		end
	end

	// stop flag
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stop_seen_q <= 1'b0;
		end else if (stop_det & active) begin
			stop_seen_q <= 1'b1;
		end else if (wr_ctrl & pwdata[CTL_CLR_STOP]) begin
			stop_seen_q <= 1'b0;
		end
	end

	// transmit-active: lost arbitration always wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			xmit_q <= 1'b0;
		end else if (arb_lost_q | arb_evt | timeout) begin
			xmit_q <= 1'b0;
		end else if (wr_data | (wr_ctrl & (pwdata[CTL_SEND_RSTART] | pwdata[CTL_SEND_STOP]))) begin
			xmit_q <= 1'b1;
		end else if (rd_data | (wr_ctrl & pwdata[CTL_CLR_XMIT])) begin
			xmit_q <= 1'b0;
		end
	end

	// transmit bit; repeated start loads a one, stop a zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_bit_q <= 1'b1;
		end else if (wr_ctrl & pwdata[CTL_SEND_RSTART]) begin
			tx_bit_q <= 1'b1;
		end else if (wr_ctrl & pwdata[CTL_SEND_STOP]) begin
			tx_bit_q <= 1'b0;
		end else if (wr_data) begin
			tx_bit_q <= pwdata[DAT_BIT];
		end
	end

	// repeated-start and stop sequencing in the high phase of scl
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rs_pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
			stop_rel_q <= 1'b0;
			rel_pend_q <= 1'b0;
		end else if (timeout | arb_evt) begin
			rs_pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
			stop_rel_q <= 1'b0;
			rel_pend_q <= 1'b0;
		end else if (wr_ctrl & master_q & pwdata[CTL_SEND_RSTART]) begin
			rs_pend_q <= 1'b1;
		end else if (wr_ctrl & master_q & pwdata[CTL_SEND_STOP]) begin
			stop_pend_q <= 1'b1;
			rel_pend_q <= ~mst_req_q;
		end else begin
			if (rs_pend_q & scl_s2_q & half_done & sda_pull_q) begin
				rs_pend_q <= 1'b0;
			end
			// armed only once a low phase has pulled sda; a request in the high phase waits a bit
			if (stop_pend_q & scl_s2_q & half_done & sda_pull_q) begin
				stop_pend_q <= 1'b0;
				stop_rel_q <= 1'b1;
			end
			if (stop_det) begin
				stop_rel_q <= 1'b0;
				rel_pend_q <= 1'b0;
			end
		end
	end

	// sda drive: new bit only while scl low, start or stop edge after the high time
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sda_pull_q <= 1'b0;
		end else if (gen_start_q & scl_s2_q & half_done) begin
			sda_pull_q <= 1'b1;
		end else if (!xmit_q || arb_evt) begin
			sda_pull_q <= sda_pull_q & (gen_start_q | master_q) & scl_s2_q & ~arb_evt;
		end else if (!scl_s2_q) begin
			sda_pull_q <= ~tx_bit_q;
		end else if (half_done & rs_pend_q) begin
			sda_pull_q <= 1'b1;
		end else if (half_done & stop_pend_q) begin
			sda_pull_q <= 1'b0;
		end
	end

	// bus busy between a start and a stop; clear after reset or timeout
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_q <= 1'b0;
		end else if (stop_det | timeout) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
		end
	end

	// own initial start, only once the bus is free
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gen_start_q <= 1'b0;
		end else if (start_det | timeout | ~mst_req_q) begin
			gen_start_q <= 1'b0;
		end else if (~busy_q & scl_s2_q & sda_s2_q & half_done & ~stop_pend_q) begin
			gen_start_q <= 1'b1;
		end
	end

	// mastership tracking
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			master_q <= 1'b0;
		end else if (arb_evt | timeout | (stop_det & rel_pend_q)) begin
			master_q <= 1'b0;
		end else if (gen_start_q & start_det) begin
			master_q <= 1'b1;
		end
	end

	// idle slave: deaf until the next start
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_q <= 1'b0;
		end else if (start_det | timeout) begin
			idle_q <= 1'b0;
		end else if (wr_ctrl & pwdata[CTL_IDLE]) begin
			idle_q <= 1'b1;
		end
	end

	// scl drive: master clocking plus stretching while software is busy
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_pull_q <= 1'b0;
		end else if (master_q & busy_q & scl_s2_q & half_done
				& ~(rs_pend_q | (stop_pend_q & sda_pull_q) | stop_rel_q)) begin
			scl_pull_q <= 1'b1;
		end else if (~scl_s2_q & active & attention) begin
			scl_pull_q <= 1'b1;
		end else if (master_q & ~scl_s2_q & ~half_done) begin
			scl_pull_q <= scl_pull_q; // keeps the minimum low time
		end else begin
			scl_pull_q <= 1'b0;
		end
	end

	// pins: open drain, enable low while pulling
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe_n <= ~scl_pull_q;
			sda_oe_n <= ~sda_pull_q;
		end
	end

	// read views
	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[CTL_RX] = rx_bit_q;
		ctrl_rd[CTL_ATTN] = attention;
		ctrl_rd[CTL_RDY] = bit_ready_q;
		ctrl_rd[CTL_ARB] = arb_lost_q;
		ctrl_rd[CTL_START] = start_seen_q;
		ctrl_rd[CTL_STOP] = stop_seen_q;
		ctrl_rd[CTL_MST] = master_q;
		cfg_rd = 8'h00;
		cfg_rd[CFG_SLAVE_EN] = slave_en_q;
		cfg_rd[CFG_MST_REQ] = mst_req_q;
		cfg_rd[CFG_TMR_RUN] = tmr_run_q;
		cfg_rd[CFG_RATE_HI:CFG_RATE_LO] = rate_q;
		unique case (paddr)
			CTRL_ADDR: rd_val = ctrl_rd;
			DATA_ADDR: rd_val = {rx_bit_q, 7'h00};
			CFG_ADDR: rd_val = cfg_rd;
			default: rd_val = 8'h00;
		endcase
	end

	// apb answer: one wait state, error on unmapped addresses
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= {24'h00_0000, rd_val};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

endmodule : bit_level_i2c_port

`default_nettype wire

// ===== bench/bit_level_i2c_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module i2c_port_checker
	import bit_i2c_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic ctl_rd;
	logic mapped;
	logic [9:0] hi_q;

	// how long scl has stood high; saturates so a parked bus never wraps
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hi_q <= 10'h000;
		end else if (!scl_in) begin
			hi_q <= 10'h000;
		end else if (hi_q != 10'h3FF) begin
			hi_q <= hi_q + 10'h001;
		end
	end

	// completed reads of the control word, and decoded addresses
	assign ctl_rd = pready && !pwrite && paddr == CTRL_ADDR;
	assign mapped = paddr inside {CFG_ADDR, CTRL_ADDR, DATA_ADDR};

	AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("access phase not answered after one wait state");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UNMAPPED: assert property (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h00_0000)
		else $error("mapped access wrongly answered");
	AST_ATTENTION: assert property (ctl_rd |-> prdata[CTL_ATTN] == |prdata[5:2])
		else $error("attention does not match flags");
	AST_STRETCH: assert property (ctl_rd && |prdata[5:2] && !scl_oe_n |=> !scl_oe_n)
		else $error("scl released while a flag is set");
	// from the second reset edge on, so the values before the first edge are not judged
	AST_RESET_IDLE: assert property (disable iff (1'b0) reset && $past(reset) |-> scl_oe_n && sda_oe_n && !pready)
		else $error("outputs active during reset");
	AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	AST_SDA_WINDOW: assert property ($changed(sda_oe_n) && scl_in |-> hi_q < 10'd6 || hi_q >= 10'd490)
		else $error("sda moved during scl high");
	AST_CFG_READ: assert property (pready && !pwrite && paddr == CFG_ADDR |-> prdata[5:2] == 4'h0 || prdata[4])
		else $error("config write-only bits read back");

	// main scenarios reached
	CVR_ARB: cover property (ctl_rd && prdata[CTL_ARB]);
	CVR_ERR: cover property (pready && pslverr);
	CVR_START: cover property ($fell(sda_oe_n) && scl_in);
endmodule : i2c_port_checker

bind bit_level_i2c_port i2c_port_checker chk_u (
	.clk(clk),
	.reset(reset),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.scl_in(scl_in),
	.scl_out(scl_out),
	.scl_oe_n(scl_oe_n),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n)
);

`default_nettype wire

// ===== bench/i2c_far_party.sv
`timescale 1ns/100ps
`default_nettype none

// another transmitter on the bus; it can only pull sda low
module i2c_far_party (
	input wire logic clk,
	input wire logic scl,
	input wire logic pull_cmd,
	output logic sda_pull_n
);
	initial sda_pull_n = 1'b1;

	// data moves only while scl is low, so this party never fakes a start or stop
	always @(posedge clk) begin
		if (!scl) begin
			sda_pull_n <= !pull_cmd;
		end
	end
endmodule : i2c_far_party

`default_nettype wire

// ===== bench/bit_level_i2c_port_tb.sv
`timescale 1ns/100ps
`default_nettype none

module bit_level_i2c_port_tb
	import bit_i2c_pkg::*;
;
	logic clk;
	logic reset;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic scl_oe_n;
	logic sda_oe_n;
	logic party_n;
	logic pull_cmd;
	logic scl;
	logic sda;
	logic [7:0] rd;
	logic err;
	int miscompares;
	int tests_run;

	// open-drain lines with pull-ups
	assign scl = scl_oe_n;
	assign sda = sda_oe_n & party_n;

	bit_level_i2c_port #(.TIMEOUT_CYCLES(200)) dut_u (
		.clk(clk),
		.reset(reset),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.scl_in(scl),
		.scl_out(),
		.scl_oe_n(scl_oe_n),
		.sda_in(sda),
		.sda_out(),
		.sda_oe_n(sda_oe_n)
	);

	i2c_far_party party_u (
		.clk(clk),
		.scl(scl),
		.pull_cmd(pull_cmd),
		.sda_pull_n(party_n)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed; a slave that never answers is left to the hang guard
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// polls the control word until a flag in the mask shows; bounded
	task automatic wait_ctl(input logic [7:0] m);
		int k;
		k = 0;
		do begin
			apb(1'b0, CTRL_ADDR, 8'h00);
			k++;
		end while ((rd & m) == 8'h00 && k < 2000);
		// a poll that runs out counts against the run
		if ((rd & m) == 8'h00) begin
			miscompares++;
		end
		apb(1'b0, CTRL_ADDR, 8'h00);
	endtask : wait_ctl

	// become master, send a one, optionally lose it to the far party
	task automatic run_bit(input logic contest, input logic [7:0] exp);
		apb(1'b1, CFG_ADDR, 8'h40);
		wait_ctl(8'h20);
		check(rd & 8'h7F, 8'h62);
		pull_cmd <= contest;
		apb(1'b1, DATA_ADDR, 8'h80);
		apb(1'b0, CTRL_ADDR, 8'h00);
		check(rd & 8'h7F, 8'h02);
		wait_ctl(8'h30);
		check(rd, exp);
	endtask : run_bit

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	initial begin
		miscompares = 0;
		tests_run = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pull_cmd = 1'b0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// reset values, write-only and unmapped places
		apb(1'b0, CFG_ADDR, 8'h00);
		check(rd, CFG_RESET);
		apb(1'b0, CTRL_ADDR, 8'h00);
		check(rd & 8'h7E, 8'h00);
		apb(1'b1, CFG_ADDR, 8'hB3);
		apb(1'b0, CFG_ADDR, 8'h00);
		check(rd, 8'h93);
		apb(1'b0, 8'hE0, 8'h00);
		check({7'h00, err}, 8'h01);
		apb(1'b1, CFG_ADDR, 8'h00);
		$display("test registers done");
		// uncontested bit, then stop with the request dropped first
		run_bit(1'b0, 8'hE2);
		apb(1'b1, CFG_ADDR, 8'h00);
		apb(1'b1, CTRL_ADDR, 8'h21);
		wait_ctl(8'h04);
		check(rd & 8'h46, 8'h44);
		apb(1'b1, CTRL_ADDR, 8'h3C);
		apb(1'b0, CTRL_ADDR, 8'h00);
		check(rd & 8'h7E, 8'h00);
		$display("test master stop done");
		// far party holds sda low against our one
		run_bit(1'b1, 8'h70);
		pull_cmd <= 1'b0;
		apb(1'b0, DATA_ADDR, 8'h00);
		check(rd, 8'h00);
		apb(1'b0, CTRL_ADDR, 8'h00);
		check(rd & 8'h7E, 8'h50);
		apb(1'b1, CTRL_ADDR, 8'h30);
		apb(1'b0, CTRL_ADDR, 8'h00);
		check(rd & 8'h7E, 8'h00);
		apb(1'b1, CFG_ADDR, 8'h00);
		$display("test arbitration done");
		results();
	end

	// hang guard, several times the expected run
	initial begin
		#800000;
		miscompares++;
		results();
	end
endmodule : bit_level_i2c_port_tb

`default_nettype wire
